// File: dv/rtc_time_access_alarm_bench.sv
// Testbench: byte-port tasks driving hold-off, register and alarm scenarios
`timescale 1ns/10ps
`default_nettype none
module rtc_time_access_alarm_bench;
  logic       clk;
  logic       rst;
  logic       acc;
  logic       pld;
  logic [7:0] pdat;
  logic       bwr;
  logic [7:0] wdat;
  logic       brd;
  logic [7:0] rdat;
  logic       rvld;
  logic       tick;
  logic [7:0] t_sec;
  logic [7:0] t_min;
  logic [7:0] t_hour;
  logic [7:0] t_mday;
  logic [7:0] t_wday;
  logic [7:0] t_mon;
  logic [7:0] t_year;
  logic       adv;
  logic       tws;
  logic [7:0] twa;
  logic [7:0] twd;
  logic       h12;
  logic       irq_on;
  logic       af_clr;
  logic       osc_stop;
  logic       osc_clr;
  logic       af;
  logic       osc_flag;
  logic       int_n;
  int         n_mismatch;
  int         checked;
  int         n_adv;
  int         cycles;
  int         a0;
  logic [7:0] d;
  logic [7:0] exp_t [7] = '{8'h20, 8'h00, 8'h00, 8'h01, 8'h00, 8'h01, 8'h00};
  logic [7:0] exp_m [5] = '{8'hff, 8'hff, 8'hbf, 8'hbf, 8'h87};

  rtc_time_access_alarm DUT (.REF_CLK(clk), .SYS_RST(rst), .ACC_ACTIVE(acc), .PTR_LOAD(pld),
    .PTR_DATA(pdat), .BYTE_WR(bwr), .WR_DATA(wdat), .BYTE_RD(brd), .RD_DATA(rdat),
    .RD_VALID(rvld), .TICK_1HZ(tick), .TIME_SEC(t_sec), .TIME_MIN(t_min), .TIME_HOUR(t_hour),
    .TIME_MDAY(t_mday), .TIME_WDAY(t_wday), .TIME_MONTH(t_mon), .TIME_YEAR(t_year),
    .TIME_ADVANCE(adv), .TIME_WR_STB(tws), .TIME_WR_ADDR(twa), .TIME_WR_DATA(twd),
    .HOUR_12_MODE(h12), .ALARM_IRQ_ON(irq_on), .ALARM_FLAG_CLR(af_clr), .OSC_STOPPED(osc_stop),
    .OSC_FLAG_CLR(osc_clr), .ALARM_FLAG(af), .OSC_HALT_FLAG(osc_flag), .INT_N(int_n));

  rtc_time_model partner (.clk(clk), .rst(rst), .advance(adv), .wr_stb(tws), .wr_addr(twa),
    .wr_data(twd), .sec(t_sec), .min(t_min), .hour(t_hour), .mday(t_mday), .wday(t_wday),
    .month(t_mon), .year(t_year));

  // ----------------------------------------------------------------
  // Clock, advance counter, timeout
  // ----------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Counted on the falling edge, away from the launching edge, so the advance pulse is settled
  always @(negedge clk)
  begin
    cycles++;
    if (adv === 1'b1)
      n_adv++;
    if (cycles == 20000)
    begin
      n_mismatch++;
      complete_run();
    end
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] expv);
    checked++;
    if (seen !== expv)
    begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", name, expv, seen);
    end
  endtask

  task automatic ptr(input logic [7:0] a);
    @(negedge clk) pld = 1'b1;
    pdat = a;
    @(negedge clk) pld = 1'b0;
  endtask

  task automatic wr(input logic [7:0] v);
    @(negedge clk) bwr = 1'b1;
    wdat = v;
    @(negedge clk) bwr = 1'b0;
  endtask

  task automatic rd(output logic [7:0] v);
    int n;
    @(negedge clk) brd = 1'b1;
    @(negedge clk) brd = 1'b0;
    // Bounded wait for the read answer
    for (n = 0; n < 4 && rvld !== 1'b1; n++)
      @(negedge clk);
    check("rd_valid", {7'h0, rvld}, 8'h01);
    v = rdat;
  endtask

  task automatic pulse_tick();
    @(negedge clk) tick = 1'b1;
    @(negedge clk) tick = 1'b0;
    repeat (6) @(negedge clk);
  endtask

  task automatic clr_alarm();
    @(negedge clk) af_clr = 1'b1;
    @(negedge clk) af_clr = 1'b0;
    repeat (2) @(negedge clk);
  endtask

  task automatic complete_run();
    if (n_mismatch == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    {rst, acc, pld, pdat, bwr, wdat, brd, tick, h12, irq_on, af_clr, osc_stop, osc_clr} = '0;
    rst = 1'b1;
    n_mismatch = 0;
    checked = 0;
    n_adv = 0;
    cycles = 0;
    repeat (5) @(negedge clk);
    rst = 1'b0;
    check("osc_flag", {7'h0, osc_flag}, 8'h01);
    check("int_n", {7'h0, int_n}, 8'h01);
    // Match registers out of reset, then an unmapped read
    ptr(8'h0b);
    for (int i = 0; i < 5; i++)
    begin
      rd(d);
      check("match_reset", d, 8'h80);
    end
    ptr(8'h01);
    rd(d);
    check("unmapped", d, 8'h00);
    // Unused bits of match registers read back zero
    ptr(8'h0b);
    for (int i = 0; i < 5; i++)
      wr(8'hff);
    ptr(8'h0b);
    for (int i = 0; i < 5; i++)
    begin
      rd(d);
      check("match_mask", d, exp_m[i]);
    end
    // Seconds set in one access, then two held ticks replayed as one advance
    acc = 1'b1;
    ptr(8'h04);
    wr(8'h20);
    ptr(8'h04);
    for (int i = 0; i < 7; i++)
    begin
      rd(d);
      check("time_read", d, exp_t[i]);
    end
    a0 = n_adv;
    pulse_tick();
    pulse_tick();
    check("held_adv", 8'(n_adv - a0), 8'h00);
    @(negedge clk) acc = 1'b0;
    repeat (4) @(negedge clk);
    check("replay_adv", 8'(n_adv - a0), 8'h01);
    // Minutes match held over seconds: flags once
    ptr(8'h0b);
    for (int i = 0; i < 5; i++)
      wr(i == 1 ? 8'h00 : 8'h80);
    check("af_idle", {7'h0, af}, 8'h00);
    pulse_tick();
    check("af_set", {7'h0, af}, 8'h01);
    check("int_off", {7'h0, int_n}, 8'h01);
    @(negedge clk) irq_on = 1'b1;
    repeat (2) @(negedge clk);
    check("int_on", {7'h0, int_n}, 8'h00);
    clr_alarm();
    check("af_clr", {7'h0, af}, 8'h00);
    check("int_clr", {7'h0, int_n}, 8'h01);
    pulse_tick();
    check("af_hold", {7'h0, af}, 8'h00);
    // Seconds match with minutes ignored
    ptr(8'h0b);
    // Seconds stand at 23h here; the match lies two updates ahead
    wr(8'h25);
    wr(8'h80);
    pulse_tick();
    check("af_early", {7'h0, af}, 8'h00);
    pulse_tick();
    check("af_sec", {7'h0, af}, 8'h01);
    clr_alarm();
    // Everything ignored never alarms
    ptr(8'h0b);
    wr(8'h80);
    repeat (3) pulse_tick();
    check("af_none", {7'h0, af}, 8'h00);
    // Hour match in 12-hour mode honours the meridiem bit
    h12 = 1'b1;
    acc = 1'b1;
    ptr(8'h06);
    wr(8'h05);
    acc = 1'b0;
    ptr(8'h0d);
    wr(8'h25);
    repeat (2) pulse_tick();
    check("af_pm", {7'h0, af}, 8'h00);
    ptr(8'h0d);
    wr(8'h05);
    pulse_tick();
    check("af_am", {7'h0, af}, 8'h01);
    // Day and weekday fields: a weekday mismatch blocks, then a fresh match sets
    clr_alarm();
    ptr(8'h0e);
    wr(8'h01);
    wr(8'h01);
    pulse_tick();
    check("af_wday_off", {7'h0, af}, 8'h00);
    ptr(8'h0f);
    wr(8'h00);
    pulse_tick();
    check("af_wday", {7'h0, af}, 8'h01);
    // Oscillator halt flag
    @(negedge clk) osc_clr = 1'b1;
    @(negedge clk) osc_clr = 1'b0;
    repeat (2) @(negedge clk);
    check("osc_clr", {7'h0, osc_flag}, 8'h00);
    @(negedge clk) osc_stop = 1'b1;
    repeat (2) @(negedge clk);
    osc_stop = 1'b0;
    repeat (3) @(negedge clk);
    check("osc_sticky", {7'h0, osc_flag}, 8'h01);
    complete_run();
  end
endmodule
`default_nettype wire

// File: dv/rtc_time_model.sv
// Partner model: time counters driven by the advance and write strobes
`timescale 1ns/10ps
`default_nettype none
module rtc_time_model
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Control from the block
  input  wire logic       advance,
  input  wire logic       wr_stb,
  input  wire logic [7:0] wr_addr,
  input  wire logic [7:0] wr_data,
  // Running time
  output logic      [7:0] sec,
  output logic      [7:0] min,
  output logic      [7:0] hour,
  output logic      [7:0] mday,
  output logic      [7:0] wday,
  output logic      [7:0] month,
  output logic      [7:0] year
);
  // Only seconds roll; minutes stay put so a long match can be held
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      {sec, min, hour, wday, year} <= 40'h0;
      mday  <= 8'h01;
      month <= 8'h01;
    end
    else if (wr_stb)
    begin
      case (wr_addr)
        8'h04:   sec   <= wr_data;
        8'h05:   min   <= wr_data;
        8'h06:   hour  <= wr_data;
        8'h07:   mday  <= wr_data;
        8'h08:   wday  <= wr_data;
        8'h09:   month <= wr_data;
        default: year  <= wr_data;
      endcase
    end
    else if (advance)
    begin
      if (sec[3:0] != 4'h9)
        sec <= sec + 8'h01;
      else if (sec[7:4] != 4'h5)
        sec <= {sec[7:4] + 4'h1, 4'h0};
      else
        sec <= 8'h00;
    end
  end
endmodule
`default_nettype wire

// File: hw/alarm_compare.sv
// Alarm comparator: enabled match fields against the running time
`timescale 1ns/10ps
`default_nettype none
module alarm_compare
(
  // Alarm settings and running time
  input  wire rtc_alarm_pkg::time_fields_t match_regs,
  input  wire rtc_alarm_pkg::time_fields_t cur_time,
  input  wire logic                        hour_12_mode,
  // Result
  output logic                             all_match,
  output logic                             all_disabled
);

  // ----------------------------------------------------------------
  // Field compare
  // ----------------------------------------------------------------
  function automatic logic field_ok(input logic [7:0] alarm, input logic [7:0] now,
                                    input logic [7:0] mask);
    field_ok = alarm[rtc_alarm_pkg::MATCH_DISABLE_BIT] || ((alarm & mask) == (now & mask));
  endfunction

  // In 12-hour mode the meridiem bit is compared apart; the mask keeps one tens bit and the units
  function automatic logic hour_ok(input logic [7:0] alarm, input logic [7:0] now,
                                   input logic mode12);
    logic meridiem_eq;
    meridiem_eq = alarm[rtc_alarm_pkg::MERIDIEM_BIT] == now[rtc_alarm_pkg::MERIDIEM_BIT];
    if (mode12)
      hour_ok = field_ok(alarm, now, rtc_alarm_pkg::HOUR12_CMP_MASK) &&
                (alarm[rtc_alarm_pkg::MATCH_DISABLE_BIT] || meridiem_eq);
    else
      hour_ok = field_ok(alarm, now, rtc_alarm_pkg::HOUR24_CMP_MASK);
  endfunction

  wire logic sec_ok  = field_ok(match_regs.sec, cur_time.sec, rtc_alarm_pkg::SEC_CMP_MASK);
  wire logic min_ok  = field_ok(match_regs.min, cur_time.min, rtc_alarm_pkg::MIN_CMP_MASK);
  wire logic hr_ok   = hour_ok(match_regs.hour, cur_time.hour, hour_12_mode);
  wire logic mday_ok = field_ok(match_regs.mday, cur_time.mday, rtc_alarm_pkg::MDAY_CMP_MASK);
  wire logic wday_ok = field_ok(match_regs.wday, cur_time.wday, rtc_alarm_pkg::WDAY_CMP_MASK);

  // Disabled fields pass, so they neither block nor cause a match
  assign all_match    = sec_ok && min_ok && hr_ok && mday_ok && wday_ok;
  assign all_disabled = match_regs.sec[7] && match_regs.min[7] && match_regs.hour[7] &&
                        match_regs.mday[7] && match_regs.wday[7];

endmodule
`default_nettype wire

// File: hw/rtc_alarm_pkg.sv
// Package: register map, field layout, reset values and states of the alarm block
package rtc_alarm_pkg;

  // ----------------------------------------------------------------
  // Register pointer map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_TIME_FIRST   = 8'h04;
  localparam logic [7:0] ADDR_TIME_LAST    = 8'h0a;
  localparam logic [7:0] ADDR_SEC_MATCH    = 8'h0b;
  localparam logic [7:0] ADDR_MIN_MATCH    = 8'h0c;
  localparam logic [7:0] ADDR_HOUR_MATCH   = 8'h0d;
  localparam logic [7:0] ADDR_MDAY_MATCH   = 8'h0e;
  localparam logic [7:0] ADDR_WDAY_MATCH   = 8'h0f;
  localparam logic [7:0] ADDR_LAST         = 8'h11;

  // ----------------------------------------------------------------
  // Field layout and reset values
  // ----------------------------------------------------------------
  localparam int         MATCH_DISABLE_BIT = 7;
  localparam int         MERIDIEM_BIT      = 5;
  localparam logic [7:0] MATCH_RESET       = 8'h80;
  localparam logic [7:0] SEC_WR_MASK       = 8'hff;
  localparam logic [7:0] MIN_WR_MASK       = 8'hff;
  localparam logic [7:0] HOUR_WR_MASK      = 8'hbf;
  localparam logic [7:0] MDAY_WR_MASK      = 8'hbf;
  localparam logic [7:0] WDAY_WR_MASK      = 8'h87;
  localparam logic [7:0] SEC_CMP_MASK      = 8'h7f;
  localparam logic [7:0] MIN_CMP_MASK      = 8'h7f;
  localparam logic [7:0] MDAY_CMP_MASK     = 8'h3f;
  localparam logic [7:0] WDAY_CMP_MASK     = 8'h07;
  localparam logic [7:0] HOUR12_CMP_MASK   = 8'h1f;
  localparam logic [7:0] HOUR24_CMP_MASK   = 8'h3f;

  // ----------------------------------------------------------------
  // Carriers and states
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] sec;
    logic [7:0] min;
    logic [7:0] hour;
    logic [7:0] mday;
    logic [7:0] wday;
  } time_fields_t;

  typedef enum logic [1:0] {
    ST_FREE = 2'b01,
    ST_HELD = 2'b10
  } count_state_t;

endpackage

// File: hw/rtc_time_access_alarm.sv
// Time-access hold-off, register pointer, alarm registers and alarm/oscillator flags
//
// Operation
// - Hold time counting during host access
// - Release after access, replay one pending tick
// - Seconds match: disable bit, BCD tens, units
// - Minutes match: disable bit, BCD tens, units
// - Hours match: disable, meridiem or tens, units
// - Hour mode selects hour field interpretation
// - Day match: disable, tens 0-3, units
// - Weekday match: disable bit, value 0-6
// - Full enabled match sets alarm flag
// - Disabled fields ignored in the match
// - Alarm flag sticky; sets again on new match
// - Interrupt mirrors alarm flag when enabled
// - Oscillator halt flag sticky until cleared
`timescale 1ns/10ps
`default_nettype none
module rtc_time_access_alarm
(
  // Clock and reset
  input  wire logic       REF_CLK,
  input  wire logic       SYS_RST,
  // Byte port from the serial slave engine
  input  wire logic       ACC_ACTIVE,
  input  wire logic       PTR_LOAD,
  input  wire logic [7:0] PTR_DATA,
  input  wire logic       BYTE_WR,
  input  wire logic [7:0] WR_DATA,
  input  wire logic       BYTE_RD,
  output logic      [7:0] RD_DATA,
  output logic            RD_VALID,
  // Time counters
  input  wire logic       TICK_1HZ,
  input  wire logic [7:0] TIME_SEC,
  input  wire logic [7:0] TIME_MIN,
  input  wire logic [7:0] TIME_HOUR,
  input  wire logic [7:0] TIME_MDAY,
  input  wire logic [7:0] TIME_WDAY,
  input  wire logic [7:0] TIME_MONTH,
  input  wire logic [7:0] TIME_YEAR,
  output logic            TIME_ADVANCE,
  output logic            TIME_WR_STB,
  output logic      [7:0] TIME_WR_ADDR,
  output logic      [7:0] TIME_WR_DATA,
  // Control bits and flags
  input  wire logic       HOUR_12_MODE,
  input  wire logic       ALARM_IRQ_ON,
  input  wire logic       ALARM_FLAG_CLR,
  input  wire logic       OSC_STOPPED,
  input  wire logic       OSC_FLAG_CLR,
  output logic            ALARM_FLAG,
  output logic            OSC_HALT_FLAG,
  output logic            INT_N
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  rtc_alarm_pkg::count_state_t state_ff;
  rtc_alarm_pkg::count_state_t nxt_state;
  rtc_alarm_pkg::time_fields_t match_ff;
  rtc_alarm_pkg::time_fields_t cur_time;
  logic       pending_ff;
  logic       nxt_pending;
  logic       advance_ff;
  logic       nxt_advance;
  logic       cmp_en_ff;
  logic       match_last_ff;
  logic [7:0] ptr_ff;
  logic [7:0] rd_data_ff;
  logic       rd_valid_ff;
  logic       twr_stb_ff;
  logic [7:0] twr_addr_ff;
  logic [7:0] twr_data_ff;
  logic       af_ff;
  logic       os_ff;
  logic       int_n_ff;
  logic       all_match;
  logic       all_disabled;

  // ----------------------------------------------------------------
  // Count hold-off
  // ----------------------------------------------------------------
  // Only one missed tick can be stored; a second tick in one access is lost
  always_comb
  begin
    nxt_state   = state_ff;
    nxt_pending = pending_ff;
    nxt_advance = 1'b0;
    case (state_ff)
      rtc_alarm_pkg::ST_FREE:
      begin
        if (ACC_ACTIVE)
        begin
          nxt_state   = rtc_alarm_pkg::ST_HELD;
          nxt_pending = TICK_1HZ;
        end
        else
          nxt_advance = TICK_1HZ;
      end
      rtc_alarm_pkg::ST_HELD:
      begin
        if (ACC_ACTIVE)
          nxt_pending = pending_ff | TICK_1HZ;
        else
        begin
          nxt_state   = rtc_alarm_pkg::ST_FREE;
          nxt_advance = pending_ff | TICK_1HZ;
          nxt_pending = 1'b0;
        end
      end
      default:
      begin
        nxt_state   = rtc_alarm_pkg::ST_FREE;
        nxt_pending = 1'b0;
      end
    endcase
  end

  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
    begin
      state_ff   <= rtc_alarm_pkg::ST_FREE;
      pending_ff <= 1'b0;
      advance_ff <= 1'b0;
      cmp_en_ff  <= 1'b0;
    end
    else
    begin
      state_ff   <= nxt_state;
      pending_ff <= nxt_pending;
      advance_ff <= nxt_advance;
      cmp_en_ff  <= advance_ff;
    end
  end

  // ----------------------------------------------------------------
  // Register pointer and byte access
  // ----------------------------------------------------------------
  wire logic       ptr_at_last = ptr_ff == rtc_alarm_pkg::ADDR_LAST;
  wire logic [7:0] ptr_inc     = ptr_at_last ? 8'h00 : ptr_ff + 8'h01;
  wire logic       ptr_is_time = ptr_ff >= rtc_alarm_pkg::ADDR_TIME_FIRST &&
                                 ptr_ff <= rtc_alarm_pkg::ADDR_TIME_LAST;
  wire logic       wr_sec      = BYTE_WR && ptr_ff == rtc_alarm_pkg::ADDR_SEC_MATCH;
  wire logic       wr_min      = BYTE_WR && ptr_ff == rtc_alarm_pkg::ADDR_MIN_MATCH;
  wire logic       wr_hour     = BYTE_WR && ptr_ff == rtc_alarm_pkg::ADDR_HOUR_MATCH;
  wire logic       wr_mday     = BYTE_WR && ptr_ff == rtc_alarm_pkg::ADDR_MDAY_MATCH;
  wire logic       wr_wday     = BYTE_WR && ptr_ff == rtc_alarm_pkg::ADDR_WDAY_MATCH;

  logic [7:0] rd_mux;
  always_comb
  begin
    case (ptr_ff)
      8'h04:   rd_mux = TIME_SEC;
      8'h05:   rd_mux = TIME_MIN;
      8'h06:   rd_mux = TIME_HOUR;
      8'h07:   rd_mux = TIME_MDAY;
      8'h08:   rd_mux = TIME_WDAY;
      8'h09:   rd_mux = TIME_MONTH;
      8'h0a:   rd_mux = TIME_YEAR;
      8'h0b:   rd_mux = match_ff.sec;
      8'h0c:   rd_mux = match_ff.min;
      8'h0d:   rd_mux = match_ff.hour;
      8'h0e:   rd_mux = match_ff.mday;
      8'h0f:   rd_mux = match_ff.wday;
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
    begin
      ptr_ff      <= 8'h00;
      rd_data_ff  <= 8'h00;
      rd_valid_ff <= 1'b0;
      twr_stb_ff  <= 1'b0;
      twr_addr_ff <= 8'h00;
      twr_data_ff <= 8'h00;
    end
    else
    begin
      rd_valid_ff <= BYTE_RD;
      twr_stb_ff  <= BYTE_WR && ptr_is_time;
      if (BYTE_RD)
        rd_data_ff <= rd_mux;
      if (BYTE_WR)
      begin
        twr_addr_ff <= ptr_ff;
        twr_data_ff <= WR_DATA;
      end
      if (PTR_LOAD)
        ptr_ff <= PTR_DATA;
      else if (BYTE_WR || BYTE_RD)
        ptr_ff <= ptr_inc;
    end
  end

  // ----------------------------------------------------------------
  // Alarm match registers
  // ----------------------------------------------------------------
  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
      match_ff <= {5{rtc_alarm_pkg::MATCH_RESET}};
    else
    begin
      if (wr_sec)
        match_ff.sec <= WR_DATA & rtc_alarm_pkg::SEC_WR_MASK;
      if (wr_min)
        match_ff.min <= WR_DATA & rtc_alarm_pkg::MIN_WR_MASK;
      if (wr_hour)
        match_ff.hour <= WR_DATA & rtc_alarm_pkg::HOUR_WR_MASK;
      if (wr_mday)
        match_ff.mday <= WR_DATA & rtc_alarm_pkg::MDAY_WR_MASK;
      if (wr_wday)
        match_ff.wday <= WR_DATA & rtc_alarm_pkg::WDAY_WR_MASK;
    end
  end

  // ----------------------------------------------------------------
  // Comparator and flags
  // ----------------------------------------------------------------
  assign cur_time = '{sec: TIME_SEC, min: TIME_MIN, hour: TIME_HOUR,
                      mday: TIME_MDAY, wday: TIME_WDAY};

  alarm_compare u_cmp
  (
    .match_regs   (match_ff),
    .cur_time     (cur_time),
    .hour_12_mode (HOUR_12_MODE),
    .all_match    (all_match),
    .all_disabled (all_disabled)
  );

  // Counters settle one cycle after the advance pulse, hence the delayed compare
  wire logic match_now = all_match && !all_disabled;
  wire logic af_set    = cmp_en_ff && match_now && !match_last_ff;
  wire logic nxt_af    = af_set || (af_ff && !ALARM_FLAG_CLR);
  wire logic nxt_os    = OSC_STOPPED || (os_ff && !OSC_FLAG_CLR);

  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
    begin
      match_last_ff <= 1'b0;
      af_ff         <= 1'b0;
      os_ff         <= 1'b1;
      int_n_ff      <= 1'b1;
    end
    else
    begin
      if (cmp_en_ff)
        match_last_ff <= match_now;
      af_ff    <= nxt_af;
      os_ff    <= nxt_os;
      int_n_ff <= !(nxt_af && ALARM_IRQ_ON);
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign RD_DATA       = rd_data_ff;
  assign RD_VALID      = rd_valid_ff;
  assign TIME_ADVANCE  = advance_ff;
  assign TIME_WR_STB   = twr_stb_ff;
  assign TIME_WR_ADDR  = twr_addr_ff;
  assign TIME_WR_DATA  = twr_data_ff;
  assign ALARM_FLAG    = af_ff;
  assign OSC_HALT_FLAG = os_ff;
  assign INT_N         = int_n_ff;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_hold;
    @(posedge REF_CLK) disable iff (SYS_RST) ACC_ACTIVE |=> !TIME_ADVANCE;
  endproperty
  a_hold: assert property (p_hold) else $error("time advanced during access");

  property p_release;
    @(posedge REF_CLK) disable iff (SYS_RST)
      (state_ff == rtc_alarm_pkg::ST_HELD && pending_ff && !ACC_ACTIVE) |=> TIME_ADVANCE;
  endproperty
  a_release: assert property (p_release) else $error("pending tick not replayed");

  property p_free_tick;
    @(posedge REF_CLK) disable iff (SYS_RST)
      (TICK_1HZ && !ACC_ACTIVE) |=> TIME_ADVANCE ##1 !TIME_ADVANCE;
  endproperty
  a_free_tick: assert property (p_free_tick) else $error("free tick not passed once");

  property p_sec_wr;
    @(posedge REF_CLK) disable iff (SYS_RST)
      (wr_sec && !PTR_LOAD) |=> match_ff.sec == $past(WR_DATA);
  endproperty
  a_sec_wr: assert property (p_sec_wr) else $error("seconds match not stored");

  property p_min_wr;
    @(posedge REF_CLK) disable iff (SYS_RST) wr_min |=> match_ff.min == $past(WR_DATA);
  endproperty
  a_min_wr: assert property (p_min_wr) else $error("minutes match not stored");

  property p_hour_wr;
    @(posedge REF_CLK) disable iff (SYS_RST)
      wr_hour |=> match_ff.hour == ($past(WR_DATA) & 8'hbf) && !match_ff.hour[6];
  endproperty
  a_hour_wr: assert property (p_hour_wr) else $error("hours unused bit stored");

  property p_mday_wr;
    @(posedge REF_CLK) disable iff (SYS_RST) wr_mday |=> match_ff.mday[6] == 1'b0;
  endproperty
  a_mday_wr: assert property (p_mday_wr) else $error("day unused bit stored");

  property p_wday_wr;
    @(posedge REF_CLK) disable iff (SYS_RST)
      wr_wday |=> match_ff.wday == ($past(WR_DATA) & 8'h87);
  endproperty
  a_wday_wr: assert property (p_wday_wr) else $error("weekday mask wrong");

  property p_af_set;
    @(posedge REF_CLK) disable iff (SYS_RST)
      (cmp_en_ff && match_now && !match_last_ff) |=> ALARM_FLAG;
  endproperty
  a_af_set: assert property (p_af_set) else $error("alarm flag not set on match");

  property p_all_off;
    @(posedge REF_CLK) disable iff (SYS_RST) (all_disabled && !ALARM_FLAG) |=> !ALARM_FLAG;
  endproperty
  a_all_off: assert property (p_all_off) else $error("alarm with all fields off");

  property p_af_sticky;
    @(posedge REF_CLK) disable iff (SYS_RST)
      (ALARM_FLAG && !ALARM_FLAG_CLR) |=> ALARM_FLAG;
  endproperty
  a_af_sticky: assert property (p_af_sticky) else $error("alarm flag dropped");

  property p_irq;
    @(posedge REF_CLK) disable iff (SYS_RST) ALARM_IRQ_ON |=> INT_N == !ALARM_FLAG;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not following flag");

  property p_osc;
    @(posedge REF_CLK) disable iff (SYS_RST)
      (OSC_STOPPED || (OSC_HALT_FLAG && !OSC_FLAG_CLR)) |=> OSC_HALT_FLAG;
  endproperty
  a_osc: assert property (p_osc) else $error("oscillator flag lost");

  property p_cmp;
    @(posedge REF_CLK) disable iff (SYS_RST) TIME_ADVANCE |=> cmp_en_ff;
  endproperty
  a_cmp: assert property (p_cmp) else $error("no compare after update");

  property p_ptr;
    @(posedge REF_CLK) disable iff (SYS_RST)
      ((BYTE_RD || BYTE_WR) && !PTR_LOAD && !ptr_at_last) |=> ptr_ff == $past(ptr_ff) + 8'h01;
  endproperty
  a_ptr: assert property (p_ptr) else $error("pointer did not advance");

  c_replay: cover property (@(posedge REF_CLK) disable iff (SYS_RST)
    pending_ff ##1 !ACC_ACTIVE ##1 TIME_ADVANCE);
  c_alarm:  cover property (@(posedge REF_CLK) disable iff (SYS_RST) af_set);
  c_int:    cover property (@(posedge REF_CLK) disable iff (SYS_RST) $fell(INT_N));

endmodule
`default_nettype wire
